// file: bench/test_polyphonic_tone_output_router.sv
// Self-checking bench for the tone output router.
// Assumes the command writer model drives the command pins.
`timescale 1ns/1ps

module test_polyphonic_tone_output_router;
  logic        clk;
  logic        reset_n;
  logic [5:0]  cmdData;
  logic        commandStrobe;
  logic [1:0]  footageOffsetSel;
  logic        lowPl, midFirstPl, midSecondPl;
  logic        lowSh, midFirstSh, midSecondSh, highFirstSh, highSecondSh;
  logic [6:0]  octaveShapedOut;
  logic        monoOut;
  logic [7:0]  keyDownFlag;
  logic [2:0]  attackTime, releaseTime;
  logic [1:0]  decayTime;
  logic        holdEnable, pedalEnable, percussionDisable, testMode;
  logic [4:0]  drawbarLow, drawbarMidFirst, drawbarMidSecond, drawbarHighFirst;
  logic [9:0]  route;
  int          n_fail;
  int          num_checks;
  int          cycles = 0;

  assign route = {lowPl, midFirstPl, midSecondPl, lowSh, midFirstSh, midSecondSh,
                  highFirstSh, highSecondSh, |octaveShapedOut, monoOut};

  polyphonic_tone_output_router i_dut (
    .clk(clk), .reset_n(reset_n), .cmdData(cmdData), .commandStrobe(commandStrobe),
    .footageOffsetSel(footageOffsetSel),
    .lowFootagePlainOut(lowPl), .midFirstFootagePlainOut(midFirstPl),
    .midSecondFootagePlainOut(midSecondPl), .lowFootageShapedOut(lowSh),
    .midFirstFootageShapedOut(midFirstSh), .midSecondFootageShapedOut(midSecondSh),
    .highFirstFootageShapedOut(highFirstSh), .highSecondFootageShapedOut(highSecondSh),
    .octaveShapedOut(octaveShapedOut), .monoOut(monoOut), .keyDownFlag(keyDownFlag),
    .attackTime(attackTime), .decayTime(decayTime), .releaseTime(releaseTime),
    .holdEnable(holdEnable), .pedalEnable(pedalEnable),
    .percussionDisable(percussionDisable), .drawbarLow(drawbarLow),
    .drawbarMidFirst(drawbarMidFirst), .drawbarMidSecond(drawbarMidSecond),
    .drawbarHighFirst(drawbarHighFirst), .testMode(testMode)
  );

  tone_cmd_writer i_writer (
    .clk(clk), .cmdData(cmdData), .commandStrobe(commandStrobe)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic print_verdict();
    $display("Checks made: %0d, mismatches: %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_fail++;
      print_verdict();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expected);
    num_checks++;
    if (seen !== expected) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, expected, seen);
    end
  endtask

  // Pipeline is about six clocks; ten leaves margin
  task automatic settle();
    repeat (10) @(negedge clk);
  endtask

  // Expected outputs with only channel mask b held steady high
  function automatic logic [9:0] expRoute(input logic [1:0] o, input logic [7:0] b,
                                          input logic [7:0] ex);
    logic [7:0] pl, p1, p2, sh, hs, oc;
    case (o)
      2'h0: {pl, p1, p2, sh, hs, oc} = {8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'hff};
      2'h1: {pl, p1, p2, sh, hs, oc} = {8'h00, 8'h02, 8'h04, 8'hf9, 8'hf9, 8'hf9};
      2'h2: {pl, p1, p2, sh, hs, oc} = {8'hff, 8'hff, 8'hff, 8'h78, 8'h00, 8'h80};
      default: {pl, p1, p2, sh, hs, oc} = {8'h00, 8'h02, 8'h04, 8'h78, 8'hf8, 8'h80};
    endcase
    return {|(pl & ~ex & b), |(p1 & ~ex & b), |(p2 & ~ex & b), {4{|(sh & b)}},
            |(hs & b), |(oc & b), |(8'h01 & b)};
  endfunction

  initial begin
    logic [2:0] rel [2];
    logic [1:0] dec [2];
    logic [2:0] att [2];
    logic [4:0] lvl [4];
    logic [1:0] opt;
    logic [7:0] ex;
    logic       mono0;
    rel = '{3'h5, 3'h0};
    dec = '{2'h2, 2'h3};
    att = '{3'h6, 3'h1};
    lvl = '{5'h1f, 5'h01, 5'h10, 5'h15};
    reset_n = 1'b0;
    footageOffsetSel = 2'h0;
    n_fail = 0;
    num_checks = 0;
    repeat (16) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    check("outputs at reset", 32'(route), 32'h0);
    check("pedal at reset", 32'(pedalEnable), 32'h1);
    for (int i = 0; i < 2; i++) begin
      i_writer.send({4'h8, rel[i][2:1]}, {rel[i][0], dec[i], att[i]});
      settle();
      check("envelope times", 32'({attackTime, decayTime, releaseTime}),
            32'({att[i], dec[i], rel[i]}));
      check("pedal", 32'(pedalEnable), 32'(rel[i] == 3'h0));
    end
    for (int i = 0; i < 4; i++)
      i_writer.send({4'hb + 4'(i), 2'h0}, {1'b0, lvl[i]});
    settle();
    check("drawbars", 32'({drawbarLow, drawbarMidFirst, drawbarMidSecond, drawbarHighFirst}),
          32'({lvl[0], lvl[1], lvl[2], lvl[3]}));
    i_writer.send({4'ha, 2'h1}, 6'h20);
    settle();
    check("hold and percussion", 32'({holdEnable, percussionDisable}), 32'h3);
    // Four options unmasked, then standard with two channel masks
    for (int p = 0; p < 6; p++) begin
      opt = (p < 4) ? 2'(p) : 2'h0;
      ex = (p < 4) ? 8'h00 : (p == 4) ? 8'ha5 : 8'hff;
      footageOffsetSel = 2'(p);
      i_writer.send({4'h9, ex[7:6]}, ex[5:0]);
      i_writer.send({4'ha, 2'h0}, {1'b0, opt, 3'h3});
      for (int c = 0; c < 8; c++) begin
        // Note code 12 in a valid octave holds the channel high
        i_writer.playNote(3'(c), 3'h1, 4'hc);
        settle();
        check("key down", 32'(keyDownFlag), 32'(8'h01 << c));
        check("routing", 32'(route), 32'(expRoute(opt, 8'h01 << c, ex)));
        i_writer.releaseNote(3'(c));
        settle();
        check("key up", 32'(keyDownFlag), 32'h0);
        check("silent", 32'(route), 32'h0);
      end
    end
    // Standard option, mono on mid2; octave groups, then top-note timing
    footageOffsetSel = 2'h0;
    i_writer.send({4'ha, 2'h0}, 6'h02);
    i_writer.playNote(3'h0, 3'h1, 4'hc);
    settle();
    check("octave groups", 32'(octaveShapedOut), 32'h1e);
    i_writer.playNote(3'h0, 3'h6, 4'hb);
    settle();
    mono0 = monoOut;
    for (int t = 0; t < 6400 && monoOut === mono0; t++) @(negedge clk);
    mono0 = monoOut;
    // Top tone half period is 127 ticks of 50 clocks
    repeat (6340) @(negedge clk);
    check("tone ceiling", 32'(monoOut), 32'(mono0));
    repeat (20) @(negedge clk);
    check("tone toggles", 32'(monoOut), 32'(!mono0));
    // Test address locks out further commands until reset
    i_writer.playNote(3'h0, 3'h1, 4'hc);
    i_writer.send(6'h3c, 6'h00);
    i_writer.send({4'h8, 2'h3}, 6'h3f);
    settle();
    check("test mode", 32'(testMode), 32'h1);
    check("locked times", 32'({attackTime, decayTime, releaseTime}),
          32'({att[1], dec[1], rel[1]}));
    @(negedge clk);
    reset_n = 1'b0;
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    check("after reset", 32'({route, keyDownFlag, testMode}), 32'h0);
    i_writer.playNote(3'h1, 3'h1, 4'hc);
    settle();
    check("default routing", 32'(route), 32'(expRoute(2'h0, 8'h02, 8'h00)));
    print_verdict();
  end
endmodule

// file: bench/tone_cmd_writer.sv
// Keyboard controller model that writes two-half commands to the router.
// Assumes the bench calls its tasks one at a time from a single sequence.
`timescale 1ns/1ps

module tone_cmd_writer (
  // Clock
  input  wire logic       clk,
  // Command pins
  output logic [5:0]      cmdData,
  output logic            commandStrobe
);
  initial begin
    cmdData       = 6'h00;
    commandStrobe = 1'b0;
  end

  // Halves are given D1 first; pin bit 0 carries D1
  function automatic logic [5:0] toPins(input logic [5:0] h);
    return {h[0], h[1], h[2], h[3], h[4], h[5]};
  endfunction

  // Four clocks of steady data around each edge, well above the sync depth
  task automatic send(input logic [5:0] firstHalf, input logic [5:0] secondHalf);
    @(negedge clk);
    cmdData <= toPins(firstHalf);
    repeat (4) @(negedge clk);
    commandStrobe <= 1'b1;
    repeat (4) @(negedge clk);
    cmdData <= toPins(secondHalf);
    repeat (4) @(negedge clk);
    commandStrobe <= 1'b0;
    repeat (4) @(negedge clk);
    // Released bus must not look like a held value
    cmdData <= ~cmdData;
  endtask

  task automatic playNote(input logic [2:0] ch, input logic [2:0] oct, input logic [3:0] note);
    send({1'b0, ch, 1'b1, oct[2]}, {oct[1:0], note});
  endtask

  // Octave code 0 also stops the channel so it can be reassigned
  task automatic releaseNote(input logic [2:0] ch);
    send({1'b0, ch, 2'b00}, 6'h00);
  endtask
endmodule

// file: common/tone_router_defs.svh
// Constants for the polyphonic tone output router.
// Assumes a 100 MHz core clock and a strobed six-bit command source.
//
// Summary of operation
// [R1] Eight channels pick from 96 divided tones
// [R2] Sixteen outputs: seven octave, eight footage, mono
// [R3] Octave output mixes channels inside its octave
// [R4] Footages add half-tone offset 0, 7 or 4
// [R5] Second high footage never reaches octave outputs
// [R6] No tone above 7902 Hz at 2 MHz
// [R7] Standard option: all channels on seven footages
// [R8] Sawtooth option: channels 2,3 only plain mids
// [R9] Shaped high2 only in sawtooth and info options, replaces low
// [R10] Accompaniment: 4-7 shaped, 8 on octaves
// [R11] Info option: 3/2 mids, 4-8 high2, 8 octaves
// [R12] Mono output carries channel one only
// [R13] Per-channel exclusion bits gate plain footages
// [R14] Four drawbar levels for octave footages
// [R15] Hold and pedal enabled by software
// [R16] Shared envelope times, per-channel key triggers
// [R17] Controller assigns free channel on key press
// [R18] Controller clears key-down on key release
// [R19] Twelve-bit command: rise half, fall half
// [R20] Load-control code selects output option
// [R21] Key-down bit one pressed, zero released
// [R22] New routing applies from next clock
// [R23] Reset stops channels, restores defaults
`ifndef TONE_ROUTER_DEFS_SVH
`define TONE_ROUTER_DEFS_SVH

`define CLK_PERIOD_NS   10
`define REF_PERIOD_NS   500
`define REF_DIV         (`REF_PERIOD_NS / `CLK_PERIOD_NS)
`define REF_HZ          2000000
`define TONE_MAX_HZ     7902
`define MIN_HALF_TICKS  ((`REF_HZ / 2 + `TONE_MAX_HZ - 1) / `TONE_MAX_HZ)
`define MIN_GAP_CYCLES  (`MIN_HALF_TICKS * `REF_DIV - 1)

// Half periods of the top octave in 2 MHz ticks, rounded up
`define NOTE_DIV_0  8'hef
`define NOTE_DIV_1  8'he2
`define NOTE_DIV_2  8'hd5
`define NOTE_DIV_3  8'hc9
`define NOTE_DIV_4  8'hbe
`define NOTE_DIV_5  8'hb3
`define NOTE_DIV_6  8'ha9
`define NOTE_DIV_7  8'ha0
`define NOTE_DIV_8  8'h97
`define NOTE_DIV_9  8'h8f
`define NOTE_DIV_10 8'h87
`define NOTE_DIV_11 8'h7f

`define OCT_SPAN     8'h0c
`define TONE_TOP_IDX 8'h5f
`define NOTE_COUNT   4'hc
`define OCT_OFF_LO   3'h0
`define OCT_OFF_HI   3'h7
`define OCT_LAST     3'h6
`define KOFF_FIFTH   8'h07
`define KOFF_THIRD   8'h04

`define REG_ADSR    4'h8
`define REG_MASK    4'h9
`define REG_CTRL    4'ha
`define REG_BAR_L   4'hb
`define REG_BAR_TOP 4'he
`define REG_TEST    4'hf

`define MASK_ALL    8'hff
`define MASK_NONE   8'h00
`define MASK_NO23   8'hf9
`define MASK_CH1    8'h01
`define MASK_CH2    8'h02
`define MASK_CH3    8'h04
`define MASK_CH47   8'h78
`define MASK_CH48   8'hf8
`define MASK_CH8    8'h80

`endif

// file: common/tone_router_pkg.sv
// Types for the polyphonic tone output router.
// Assumes the constants header is included by the design file.
package tone_router_pkg;
  typedef enum logic [1:0] {
    OPT_NORM = 2'h0,
    OPT_SAW  = 2'h1,
    OPT_ACC  = 2'h2,
    OPT_INFO = 2'h3
  } route_cfg_e;

  typedef enum logic [1:0] {
    ST_LOW  = 2'b01,
    ST_HIGH = 2'b10
  } strobe_state_e;
endpackage

// file: src/polyphonic_tone_output_router.sv
// Command capture, tone divider chain, channel state and output routing.
// Assumes cmdData is stable around both strobe edges; analog shaping is external.
`timescale 1ns/1ps
`include "tone_router_defs.svh"

module polyphonic_tone_output_router (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Command pins
  input  wire logic [5:0] cmdData,
  input  wire logic       commandStrobe,
  // Footage offset select: 0 none, 1 seven, 2 four half tones
  input  wire logic [1:0] footageOffsetSel,
  // Footage outputs
  output logic            lowFootagePlainOut,
  output logic            midFirstFootagePlainOut,
  output logic            midSecondFootagePlainOut,
  output logic            lowFootageShapedOut,
  output logic            midFirstFootageShapedOut,
  output logic            midSecondFootageShapedOut,
  output logic            highFirstFootageShapedOut,
  output logic            highSecondFootageShapedOut,
  // Octave and mono outputs
  output logic [6:0]      octaveShapedOut,
  output logic            monoOut,
  // Envelope, drawbar and test mode controls
  output logic [7:0]      keyDownFlag,
  output logic [2:0]      attackTime,
  output logic [1:0]      decayTime,
  output logic [2:0]      releaseTime,
  output logic            holdEnable,
  output logic            pedalEnable,
  output logic            percussionDisable,
  output logic [4:0]      drawbarLow,
  output logic [4:0]      drawbarMidFirst,
  output logic [4:0]      drawbarMidSecond,
  output logic [4:0]      drawbarHighFirst,
  output logic            testMode
);

  // Pin synchronisers
  logic [5:0] dSync1_r, dSync2_r, dSync3_r;
  logic [2:0] sSync_r;
  logic       strobeLvl_r;
  logic       strobeRise, strobeFall;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dSync1_r <= 6'h00;
      dSync2_r <= 6'h00;
      dSync3_r <= 6'h00;
      sSync_r  <= 3'h0;
    end else begin
      dSync1_r <= cmdData;
      dSync2_r <= dSync1_r;
      dSync3_r <= dSync2_r;
      sSync_r  <= {sSync_r[1:0], commandStrobe};
    end
  end

  // Level accepted only when stages two and three agree
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      strobeLvl_r <= 1'b0;
    end else if (sSync_r[1] == sSync_r[2]) begin
      strobeLvl_r <= sSync_r[2];
    end
  end

  assign strobeRise = (sSync_r[1] == sSync_r[2]) && sSync_r[2] && !strobeLvl_r;
  assign strobeFall = (sSync_r[1] == sSync_r[2]) && !sSync_r[2] && strobeLvl_r;

  // Two-phase command assembly
  tone_router_pkg::strobe_state_e state_r;
  logic [5:0]  firstHalf_r;
  logic [11:0] cmdWord_r;
  logic        cmdValid_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r     <= tone_router_pkg::ST_LOW;
      firstHalf_r <= 6'h00;
      cmdWord_r   <= 12'h000;
      cmdValid_r  <= 1'b0;
    end else begin
      cmdValid_r <= 1'b0;
      case (state_r)
        tone_router_pkg::ST_LOW: begin
          if (strobeRise) begin
            firstHalf_r <= dSync3_r; // R19
            state_r     <= tone_router_pkg::ST_HIGH;
          end
        end
        tone_router_pkg::ST_HIGH: begin
          if (strobeFall) begin
            cmdWord_r  <= {firstHalf_r, dSync3_r}; // R19
            cmdValid_r <= 1'b1;
            state_r    <= tone_router_pkg::ST_LOW;
          end
        end
        default: state_r <= tone_router_pkg::ST_LOW;
      endcase
    end
  end

  // Field decode; bus line D1 is bit 0 of each half
  logic [5:0] p1, p2;
  logic [3:0] regCode;
  logic       cmdTake;
  logic       testMode_r;
  assign p1      = cmdWord_r[11:6];
  assign p2      = cmdWord_r[5:0];
  assign regCode = {p1[0], p1[1], p1[2], p1[3]};
  // Test address locks the command port until reset
  assign cmdTake = cmdValid_r && !testMode_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      testMode_r <= 1'b0;
    end else if (cmdTake && regCode == `REG_TEST) begin
      testMode_r <= 1'b1;
    end
  end

  // Control registers
  logic [2:0] attack_r, release_r;
  logic [1:0] decay_r, monoSel_r;
  logic [7:0] excludeMask_r;
  logic       hold_r, percDis_r, nc1m_r;
  logic [4:0] drawbar_r [4];
  tone_router_pkg::route_cfg_e cfg_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      attack_r  <= 3'h0;
      decay_r   <= 2'h0;
      release_r <= 3'h0;
    end else if (cmdTake && regCode == `REG_ADSR) begin
      release_r <= {p1[4], p1[5], p2[0]}; // R16
      decay_r   <= {p2[1], p2[2]};
      attack_r  <= {p2[3], p2[4], p2[5]};
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      excludeMask_r <= 8'h00;
    end else if (cmdTake && regCode == `REG_MASK) begin
      excludeMask_r <= {p1[4], p1[5], p2[0], p2[1], p2[2], p2[3], p2[4], p2[5]}; // R13
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      percDis_r <= 1'b0;
      hold_r    <= 1'b0;
      cfg_r     <= tone_router_pkg::OPT_NORM;
      nc1m_r    <= 1'b0;
      monoSel_r <= 2'h0;
    end else if (cmdTake && regCode == `REG_CTRL) begin
      percDis_r <= p1[5];
      hold_r    <= p2[0]; // R15
      cfg_r     <= tone_router_pkg::route_cfg_e'({p2[1], p2[2]}); // R20
      nc1m_r    <= p2[3];
      monoSel_r <= {p2[4], p2[5]};
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 4; i++) drawbar_r[i] <= 5'h00;
    end else if (cmdTake && regCode >= `REG_BAR_L && regCode <= `REG_BAR_TOP) begin
      drawbar_r[2'(regCode - `REG_BAR_L)] <= {p2[1], p2[2], p2[3], p2[4], p2[5]}; // R14
    end
  end

  // 2 MHz reference tick and top octave synthesiser
  localparam logic [7:0] NOTE_DIV [12] = '{`NOTE_DIV_0, `NOTE_DIV_1, `NOTE_DIV_2,
    `NOTE_DIV_3, `NOTE_DIV_4, `NOTE_DIV_5, `NOTE_DIV_6, `NOTE_DIV_7,
    `NOTE_DIV_8, `NOTE_DIV_9, `NOTE_DIV_10, `NOTE_DIV_11};
  logic [5:0]  refCnt_r;
  logic        refTick;
  logic [95:0] tone;
  logic [7:0]  halfCnt_r [12];
  logic [7:0]  divCnt_r [12];

  assign refTick = (refCnt_r == 6'(`REF_DIV - 1));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      refCnt_r <= 6'h00;
    end else begin
      refCnt_r <= refTick ? 6'h00 : refCnt_r + 6'h01;
    end
  end

  // Each note feeds a binary chain; bit b is b octaves below the top
  for (genvar n = 0; n < 12; n++) begin : g_note
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        halfCnt_r[n] <= 8'h00;
        divCnt_r[n]  <= 8'h00;
      end else if (refTick) begin
        if (halfCnt_r[n] == NOTE_DIV[n] - 8'h01) begin
          halfCnt_r[n] <= 8'h00;
          divCnt_r[n]  <= divCnt_r[n] + 8'h01; // R1 R6
        end else begin
          halfCnt_r[n] <= halfCnt_r[n] + 8'h01;
        end
      end
    end
    for (genvar b = 0; b < 8; b++) begin : g_oct
      assign tone[(7 - b) * 12 + n] = divCnt_r[n][b]; // R1
    end
  end

  // Keeps every footage inside the 96-tone range
  function automatic logic [6:0] foldIdx(input logic [7:0] i);
    logic [7:0] v;
    v = i;
    for (int k = 0; k < 4; k++) begin
      if (v > `TONE_TOP_IDX) v = v - `OCT_SPAN; // R6
    end
    return v[6:0];
  endfunction

  logic [7:0] kOff;
  always_comb begin
    case (footageOffsetSel)
      2'h1:    kOff = `KOFF_FIFTH; // R4
      2'h2:    kOff = `KOFF_THIRD; // R4
      default: kOff = 8'h00;
    endcase
  end

  // Channel state and per-footage signals
  logic [2:0] chOct_r [8];
  logic [3:0] chNote_r [8];
  logic [7:0] keyDown_r;
  logic [4:0] chanFoot [8];
  logic [2:0] chanGrp [8][5];

  for (genvar c = 0; c < 8; c++) begin : g_chan
    logic [7:0] keyIdx;
    logic       octOk, noteOk;
    logic [4:0] sig;
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        chOct_r[c]   <= `OCT_OFF_LO; // R23
        chNote_r[c]  <= 4'h0;
        keyDown_r[c] <= 1'b0;
      end else if (cmdTake && regCode == 4'(c)) begin
        keyDown_r[c] <= p1[4]; // R21 R16
        chOct_r[c]   <= {p1[5], p2[0], p2[1]};
        chNote_r[c]  <= {p2[2], p2[3], p2[4], p2[5]};
      end
    end
    assign octOk  = chOct_r[c] != `OCT_OFF_LO && chOct_r[c] != `OCT_OFF_HI;
    assign noteOk = chNote_r[c] < `NOTE_COUNT;
    assign keyIdx = 8'(({5'h00, chOct_r[c]} - 8'h01) * `OCT_SPAN) + {4'h0, chNote_r[c]};
    for (genvar f = 0; f < 5; f++) begin : g_foot
      logic [6:0] idx;
      assign idx = foldIdx(keyIdx + kOff + 8'(`OCT_SPAN * f)); // R4
      // Unused note idles high, unused octave idles low
      assign sig[f] = octOk && (noteOk ? tone[idx] : 1'b1);
      assign chanGrp[c][f] = (idx / 7'(`OCT_SPAN)) > 7'(`OCT_LAST) ?
                             `OCT_LAST : 3'(idx / 7'(`OCT_SPAN));
    end
    assign chanFoot[c] = sig;
  end

  // Routing masks per option, bit c is channel c+1
  logic [7:0] plainMask [3];
  logic [7:0] shapedMask, hiTwoMask, octMask;
  always_comb begin
    case (cfg_r)
      tone_router_pkg::OPT_SAW: begin
        plainMask[0] = `MASK_NONE; // R9
        plainMask[1] = `MASK_CH2; // R8
        plainMask[2] = `MASK_CH3; // R8
        shapedMask   = `MASK_NO23; // R8
        hiTwoMask    = `MASK_NO23; // R9
        octMask      = `MASK_NO23; // R8
      end
      tone_router_pkg::OPT_ACC: begin
        plainMask[0] = `MASK_ALL; // R10
        plainMask[1] = `MASK_ALL;
        plainMask[2] = `MASK_ALL;
        shapedMask   = `MASK_CH47; // R10
        hiTwoMask    = `MASK_NONE;
        octMask      = `MASK_CH8; // R10
      end
      tone_router_pkg::OPT_INFO: begin
        plainMask[0] = `MASK_NONE; // R11
        plainMask[1] = `MASK_CH2; // R11
        plainMask[2] = `MASK_CH3;
        shapedMask   = `MASK_CH47; // R11
        hiTwoMask    = `MASK_CH48; // R11
        octMask      = `MASK_CH8;
      end
      default: begin
        plainMask[0] = `MASK_ALL; // R7
        plainMask[1] = `MASK_ALL;
        plainMask[2] = `MASK_ALL;
        shapedMask   = `MASK_ALL; // R7
        hiTwoMask    = `MASK_NONE; // R9
        octMask      = `MASK_ALL; // R7
      end
    endcase
  end

  // Output mixing
  logic [2:0] plainOut_nxt;
  logic [3:0] shapedOut_nxt;
  logic       hiTwoOut_nxt;
  logic [6:0] octOut_nxt;
  logic [7:0] plainEff [3];
  logic [7:0] shapedEff, octEff;
  always_comb begin
    shapedEff = shapedMask & ~({7'h00, nc1m_r});
    octEff    = octMask & ~({7'h00, nc1m_r});
    plainOut_nxt  = 3'h0;
    shapedOut_nxt = 4'h0;
    hiTwoOut_nxt  = 1'b0;
    octOut_nxt    = 7'h00;
    for (int f = 0; f < 3; f++) plainEff[f] = plainMask[f] & ~excludeMask_r; // R13
    for (int c = 0; c < 8; c++) begin
      for (int f = 0; f < 3; f++) begin
        plainOut_nxt[f] = plainOut_nxt[f] | (plainEff[f][c] & chanFoot[c][f]);
      end
      for (int f = 0; f < 4; f++) begin
        shapedOut_nxt[f] = shapedOut_nxt[f] | (shapedEff[c] & chanFoot[c][f]);
        // Only four footages feed the octaves, never the second high
        if (octEff[c] && chanFoot[c][f]) octOut_nxt[chanGrp[c][f]] = 1'b1; // R3 R5
      end
      hiTwoOut_nxt = hiTwoOut_nxt | (hiTwoMask[c] & chanFoot[c][4]); // R9
    end
  end

  // Registered outputs; routing changes show one clock after capture
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lowFootagePlainOut         <= 1'b0;
      midFirstFootagePlainOut    <= 1'b0;
      midSecondFootagePlainOut   <= 1'b0;
      lowFootageShapedOut        <= 1'b0;
      midFirstFootageShapedOut   <= 1'b0;
      midSecondFootageShapedOut  <= 1'b0;
      highFirstFootageShapedOut  <= 1'b0;
      highSecondFootageShapedOut <= 1'b0;
      octaveShapedOut            <= 7'h00;
      monoOut                    <= 1'b0;
    end else begin
      lowFootagePlainOut         <= plainOut_nxt[0]; // R22 R2
      midFirstFootagePlainOut    <= plainOut_nxt[1];
      midSecondFootagePlainOut   <= plainOut_nxt[2];
      lowFootageShapedOut        <= shapedOut_nxt[0];
      midFirstFootageShapedOut   <= shapedOut_nxt[1];
      midSecondFootageShapedOut  <= shapedOut_nxt[2];
      highFirstFootageShapedOut  <= shapedOut_nxt[3];
      highSecondFootageShapedOut <= hiTwoOut_nxt;
      octaveShapedOut            <= octOut_nxt; // R22
      monoOut                    <= chanFoot[0][monoSel_r]; // R12
    end
  end

  assign keyDownFlag       = keyDown_r;
  assign attackTime        = attack_r;
  assign decayTime         = decay_r;
  assign releaseTime       = release_r;
  assign holdEnable        = hold_r;
  assign pedalEnable       = (release_r == 3'h0); // R15
  assign percussionDisable = percDis_r;
  assign drawbarLow        = drawbar_r[0];
  assign drawbarMidFirst   = drawbar_r[1];
  assign drawbarMidSecond  = drawbar_r[2];
  assign drawbarHighFirst  = drawbar_r[3];
  assign testMode          = testMode_r;

  // Gap between toggles of the highest tone
  logic [13:0] topGap_r;
  logic        topToggle;
  assign topToggle = refTick && (halfCnt_r[11] == NOTE_DIV[11] - 8'h01);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      topGap_r <= 14'h0000;
    end else begin
      topGap_r <= topToggle ? 14'h0000 : (&topGap_r ? topGap_r : topGap_r + 14'h0001);
    end
  end

  a_tone_ceiling: assert property (@(posedge clk) disable iff (!reset_n) // R6
    topToggle |-> topGap_r >= 14'(`MIN_GAP_CYCLES)) else $error("tone above ceiling");
  a_strobe_halves: assert property (@(posedge clk) disable iff (!reset_n) // R19
    cmdValid_r |-> $past(state_r) == tone_router_pkg::ST_HIGH && $past(strobeFall))
    else $error("command without two strobe edges");
  a_key_down: assert property (@(posedge clk) disable iff (!reset_n) // R21
    cmdTake && !regCode[3] |=> keyDown_r[$past(regCode[2:0])] == $past(p1[4]))
    else $error("key-down flag not taken");
  a_route_latency: assert property (@(posedge clk) disable iff (!reset_n) // R22
    cmdTake && regCode == `REG_CTRL |=> cfg_r == $past({p2[1], p2[2]}))
    else $error("option code not applied");
  a_high2_option: assert property (@(posedge clk) disable iff (!reset_n) // R9
    $past(cfg_r) inside {tone_router_pkg::OPT_NORM, tone_router_pkg::OPT_ACC}
    |-> !highSecondFootageShapedOut) else $error("high2 out of its option");
  a_mono_channel: assert property (@(posedge clk) disable iff (!reset_n) // R12
    ##1 monoOut == $past(chanFoot[0][monoSel_r])) else $error("mono not channel one");
  a_plain_exclude: assert property (@(posedge clk) disable iff (!reset_n) // R13
    &excludeMask_r [*2] |-> !midFirstFootagePlainOut && !midSecondFootagePlainOut)
    else $error("excluded channel on plain output");
  a_accomp_bass: assert property (@(posedge clk) disable iff (!reset_n) // R10
    $past(cfg_r) == tone_router_pkg::OPT_ACC && $past(chanFoot[7]) == 5'h00
    |-> octaveShapedOut == 7'h00) else $error("octaves carry more than channel eight");
  a_reset_default: assert property (@(posedge clk) // R23
    $rose(reset_n) |-> cfg_r == tone_router_pkg::OPT_NORM && keyDown_r == 8'h00)
    else $error("reset defaults lost");

endmodule
